// *** dtc_debug_trigger_control.sv ***
`timescale 1ns/1ps
// Functional notes
// - Bit 7 enables the module; cannot be set while secure.
// - Control register readable and writable at any time.
// - Arm bit 6 enables comparing and capturing into the FIFO.
// - Writing one to arm sets arm, and sets the armed status flag only if the same write also has enable (bit 7) one.
// - Run completion clears arm by hardware.
// - Writing zero to arm or enable stops the run immediately.
// - Bit 5 selects tag (1) or force (0) break requests.
// - Tag select has no effect while breaks are disabled.
// - Bit 4 enables break requests on trigger events.
// - Triggers still capture to the FIFO with breaks disabled.
// - End trace breaks when the qualified trigger occurs.
// - Begin trace breaks once the FIFO is full.
// - Trigger source select does not change break timing.
// - Bit 3 picks comparator A cycle: 0 write, 1 read.
// - Bit 2 on enables direction qualification of comparator A.
// - Bit 1 picks comparator B cycle: 0 write, 1 read.
// - With B qualification off, direction ignored for comparator B.
// - Bit 0 enables direction qualification of comparator B.
module dtc_debug_trigger_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Chip security and bus direction
    input wire logic secure_i,
    input wire logic bus_read_i,
    // Raw comparator hits
    input wire logic cmp_a_hit_i,
    input wire logic cmp_b_hit_i,
    // Trigger logic and capture FIFO
    input wire logic begin_trace_i,
    input wire logic trigger_source_select_i,
    input wire logic fifo_full_i,
    input wire logic run_done_i,
    // Outputs to comparators and FIFO
    output logic cmp_a_match_o,
    output logic cmp_b_match_o,
    output logic capture_o,
    output logic module_enabled_o,
    output logic armed_o,
    // CPU break interface
    output logic brk_req_o,
    output logic brk_tag_o,
    // Interrupt
    output logic irq_o
);

    dtc_pkg::dtc_state_t st;
    dtc_pkg::dtc_state_t next_st;

    logic access;
    logic wr_ctl;
    logic [7:0] wr_val;
    logic qual_a;
    logic qual_b;
    logic trigger;
    logic active;
    logic stop;
    logic [2:0] events;

    assign access = wb_cyc_i && wb_stb_i && !st.ack;
    assign wr_ctl = access && wb_we_i && wb_sel_i[0]
        && (wb_adr_i == dtc_pkg::ADDR_CONTROL);
    assign wr_val = wb_dat_i[7:0];
    assign active = st.control[dtc_pkg::BIT_ENABLE]
        && st.control[dtc_pkg::BIT_ARM];

    // Direction qualification per comparator
    assign qual_a = !st.control[dtc_pkg::BIT_CMP_A_QUAL]
        || (bus_read_i == st.control[dtc_pkg::BIT_CMP_A_DIR]);
    assign qual_b = !st.control[dtc_pkg::BIT_CMP_B_QUAL]
        || (bus_read_i == st.control[dtc_pkg::BIT_CMP_B_DIR]);
    assign cmp_a_match_o = active && cmp_a_hit_i && qual_a;
    assign cmp_b_match_o = active && cmp_b_hit_i && qual_b;
    // Trigger source only chooses which match counts
    assign trigger = trigger_source_select_i ? cmp_b_match_o
        : cmp_a_match_o;

    assign stop = wr_ctl && (!wr_val[dtc_pkg::BIT_ARM]
        || !wr_val[dtc_pkg::BIT_ENABLE]);

    always_comb begin
        next_st = st;
        events = 3'h0;
        next_st.ack = access;
        next_st.capture = 1'b0;
        next_st.brk.brk_req = 1'b0;
        if (wr_ctl) begin
            next_st.control = wr_val;
            if (secure_i) begin
                // Enable can be cleared but never set while secure
                next_st.control[dtc_pkg::BIT_ENABLE] =
                    wr_val[dtc_pkg::BIT_ENABLE]
                    && st.control[dtc_pkg::BIT_ENABLE];
            end
            if (wr_val[dtc_pkg::BIT_ARM]) begin
                next_st.armed_status_flag = 1'b1;
            end
        end
        if (stop) begin
            next_st.run = dtc_pkg::DTC_IDLE;
            next_st.armed_status_flag = 1'b0;
        end else begin
            case (st.run)
                dtc_pkg::DTC_IDLE: begin
                    if (active) begin
                        next_st.run = dtc_pkg::DTC_RUN;
                    end
                end
                dtc_pkg::DTC_RUN: begin
                    if (!active) begin
                        next_st.run = dtc_pkg::DTC_IDLE;
                    end else if (trigger) begin
                        events[dtc_pkg::IRQ_TRIGGER] = 1'b1;
                        next_st.capture = 1'b1;
                        if (begin_trace_i) begin
                            next_st.run = dtc_pkg::DTC_FILL;
                        end else begin
                            // End trace: break on the trigger itself
                            next_st.brk.brk_req =
                                st.control[dtc_pkg::BIT_BRK_EN];
                            next_st.run = dtc_pkg::DTC_IDLE;
                            next_st.control[dtc_pkg::BIT_ARM] = 1'b0;
                            next_st.armed_status_flag = 1'b0;
                            events[dtc_pkg::IRQ_RUN_DONE] = 1'b1;
                        end
                    end else if (run_done_i) begin
                        next_st.run = dtc_pkg::DTC_IDLE;
                        next_st.control[dtc_pkg::BIT_ARM] = 1'b0;
                        next_st.armed_status_flag = 1'b0;
                        events[dtc_pkg::IRQ_RUN_DONE] = 1'b1;
                    end
                end
                dtc_pkg::DTC_FILL: begin
                    next_st.capture = active;
                    if (!active) begin
                        next_st.run = dtc_pkg::DTC_IDLE;
                    end else if (fifo_full_i) begin
                        // Begin trace: break once the FIFO is full
                        next_st.capture = 1'b0;
                        next_st.brk.brk_req =
                            st.control[dtc_pkg::BIT_BRK_EN];
                        next_st.run = dtc_pkg::DTC_IDLE;
                        next_st.control[dtc_pkg::BIT_ARM] = 1'b0;
                        next_st.armed_status_flag = 1'b0;
                        events[dtc_pkg::IRQ_RUN_DONE] = 1'b1;
                    end
                end
                default: begin
                    next_st.run = dtc_pkg::DTC_IDLE;
                end
            endcase
        end
        next_st.brk.brk_tag = next_st.brk.brk_req
            && st.control[dtc_pkg::BIT_TAG];
        events[dtc_pkg::IRQ_BREAK] = next_st.brk.brk_req;

        // Read data and read-to-clear interrupt status
        next_st.rdata = 32'h0;
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                dtc_pkg::ADDR_CONTROL: begin
                    next_st.rdata = {24'h0, st.control};
                end
                dtc_pkg::ADDR_STATUS: begin
                    next_st.rdata[dtc_pkg::STAT_ARMED] =
                        st.armed_status_flag;
                    next_st.rdata[dtc_pkg::STAT_ARM_BIT] =
                        st.control[dtc_pkg::BIT_ARM];
                end
                dtc_pkg::ADDR_INT_STATUS: begin
                    next_st.rdata = {29'h0, st.int_status};
                    next_st.int_status = 3'h0;
                end
                dtc_pkg::ADDR_INT_MASK: begin
                    next_st.rdata = {29'h0, st.int_mask};
                end
                default: begin
                    next_st.rdata = 32'h0;
                end
            endcase
        end
        if (access && wb_we_i && wb_sel_i[0]
            && wb_adr_i == dtc_pkg::ADDR_INT_MASK) begin
            next_st.int_mask = wb_dat_i[2:0];
        end
        // Set wins over read clear
        next_st.int_status = next_st.int_status | events;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.control <= dtc_pkg::CONTROL_RESET;
            st.armed_status_flag <= 1'b0;
            st.run <= dtc_pkg::DTC_IDLE;
            st.int_status <= dtc_pkg::IRQ_RESET;
            st.int_mask <= dtc_pkg::IRQ_RESET;
            st.ack <= 1'b0;
            st.rdata <= 32'h0;
            st.capture <= 1'b0;
            st.brk <= 2'h0;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign capture_o = st.capture;
    assign brk_req_o = st.brk.brk_req;
    assign brk_tag_o = st.brk.brk_tag;
    assign module_enabled_o = st.control[dtc_pkg::BIT_ENABLE];
    assign armed_o = st.armed_status_flag;
    assign irq_o = |(st.int_status & st.int_mask);

    // Reset and register bus
    reset_clear_a: assert property (
        @(posedge clk_i)
        rst_i |=> st.control == dtc_pkg::CONTROL_RESET
        && !brk_req_o && !capture_o && !wb_ack_o)
        else $error("state not cleared by reset");

    ack_latency_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        access |=> wb_ack_o)
        else $error("access not acknowledged");

    ack_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    // Control writes and run control
    no_secure_en_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        secure_i && !st.control[dtc_pkg::BIT_ENABLE]
        |=> !st.control[dtc_pkg::BIT_ENABLE])
        else $error("enable set while secure");

    arm_sets_flag_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_ctl && wr_val[dtc_pkg::BIT_ARM] && wr_val[dtc_pkg::BIT_ENABLE]
        |=> armed_o && st.control[dtc_pkg::BIT_ARM])
        else $error("arm write did not set armed flag");

    stop_run_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        stop |=> st.run == dtc_pkg::DTC_IDLE && !armed_o)
        else $error("run not stopped");

    stop_no_break_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        stop |=> !brk_req_o && !capture_o)
        else $error("stopped run still acted");

    no_match_idle_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !st.control[dtc_pkg::BIT_ARM]
        |-> !cmp_a_match_o && !cmp_b_match_o)
        else $error("match while disarmed");

    no_capture_idle_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !active |=> !capture_o)
        else $error("capture while inactive");

    capture_fill_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st.run == dtc_pkg::DTC_FILL && active && !fifo_full_i && !stop
        |=> capture_o)
        else $error("capture stopped before full");

    // Break requests, trigger capture and run completion
    no_break_off_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !st.control[dtc_pkg::BIT_BRK_EN] |=> !brk_req_o && !brk_tag_o)
        else $error("break while disabled");

    tag_follows_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        brk_req_o |-> brk_tag_o == $past(st.control[dtc_pkg::BIT_TAG]))
        else $error("break type does not follow select");

    tag_needs_break_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !brk_req_o |-> !brk_tag_o)
        else $error("tag without break request");

    end_trace_brk_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st.run == dtc_pkg::DTC_RUN && active && trigger && !begin_trace_i
        && !stop && st.control[dtc_pkg::BIT_BRK_EN]
        |=> brk_req_o && !st.control[dtc_pkg::BIT_ARM])
        else $error("end trace break missing");

    trigger_capture_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st.run == dtc_pkg::DTC_RUN && active && trigger && !stop
        |=> capture_o)
        else $error("trigger not captured");

    run_done_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st.run == dtc_pkg::DTC_RUN && active && run_done_i && !trigger
        && !stop
        |=> !st.control[dtc_pkg::BIT_ARM] && !armed_o)
        else $error("run completion left arm set");

    begin_trace_brk_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st.run == dtc_pkg::DTC_FILL && active && fifo_full_i && !stop
        && st.control[dtc_pkg::BIT_BRK_EN] |=> brk_req_o)
        else $error("begin trace break missing");

    fill_waits_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st.run == dtc_pkg::DTC_FILL && !fifo_full_i |=> !brk_req_o)
        else $error("begin trace break before full");

    // Interrupt status
    irq_set_wins_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (events != 3'h0)
        |=> (st.int_status & $past(events)) == $past(events))
        else $error("event lost to read clear");

    irq_read_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        access && !wb_we_i && wb_adr_i == dtc_pkg::ADDR_INT_STATUS
        && events == 3'h0 |=> st.int_status == 3'h0)
        else $error("status not cleared by read");

    // Comparator direction qualification
    dir_a_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        active && cmp_a_hit_i && st.control[dtc_pkg::BIT_CMP_A_QUAL]
        && (bus_read_i != st.control[dtc_pkg::BIT_CMP_A_DIR])
        |-> !cmp_a_match_o)
        else $error("comparator A wrong direction");

    dir_a_pass_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        active && cmp_a_hit_i && st.control[dtc_pkg::BIT_CMP_A_QUAL]
        && (bus_read_i == st.control[dtc_pkg::BIT_CMP_A_DIR])
        |-> cmp_a_match_o)
        else $error("comparator A right direction lost");

    dir_a_off_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        active && cmp_a_hit_i && !st.control[dtc_pkg::BIT_CMP_A_QUAL]
        |-> cmp_a_match_o)
        else $error("comparator A qualified while off");

    dir_b_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        active && cmp_b_hit_i && !st.control[dtc_pkg::BIT_CMP_B_QUAL]
        |-> cmp_b_match_o)
        else $error("comparator B qualified while off");

    dir_b_wrong_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        active && cmp_b_hit_i && st.control[dtc_pkg::BIT_CMP_B_QUAL]
        && (bus_read_i != st.control[dtc_pkg::BIT_CMP_B_DIR])
        |-> !cmp_b_match_o)
        else $error("comparator B wrong direction");

endmodule // dtc_debug_trigger_control

// *** dtc_pkg.sv ***
package dtc_pkg;

    // Register word addresses (byte offsets)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_INT_STATUS = 4'h8;
    localparam logic [3:0] ADDR_INT_MASK = 4'hc;

    // Control register fields
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ARM = 6;
    localparam int BIT_TAG = 5;
    localparam int BIT_BRK_EN = 4;
    localparam int BIT_CMP_A_DIR = 3;
    localparam int BIT_CMP_A_QUAL = 2;
    localparam int BIT_CMP_B_DIR = 1;
    localparam int BIT_CMP_B_QUAL = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Status register fields
    localparam int STAT_ARMED = 0;
    localparam int STAT_ARM_BIT = 1;

    // Interrupt status fields
    localparam int IRQ_TRIGGER = 0;
    localparam int IRQ_RUN_DONE = 1;
    localparam int IRQ_BREAK = 2;
    localparam int IRQ_WIDTH = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    typedef enum logic [2:0] {
        DTC_IDLE = 3'b001,
        DTC_RUN = 3'b010,
        DTC_FILL = 3'b100
    } dtc_run_t;

    typedef struct packed {
        logic brk_req;
        logic brk_tag;
    } dtc_break_t;

    typedef struct packed {
        logic [7:0] control;
        logic armed_status_flag;
        dtc_run_t run;
        logic [2:0] int_status;
        logic [2:0] int_mask;
        logic ack;
        logic [31:0] rdata;
        logic capture;
        dtc_break_t brk;
    } dtc_state_t;

endpackage

// *** dtc_far_model.sv ***
`timescale 1ns/1ps
module dtc_far_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // From the block
    input wire logic capture_i,
    input wire logic brk_req_i,
    // Bench control and view
    input wire logic clear_i,
    output logic fifo_full_o,
    output logic [7:0] brk_count_o
);
    logic [3:0] fill;
    // Eight-word capture store fills, then holds full until cleared
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            fill <= 4'h0;
        end else if (capture_i && fill != 4'h8) begin
            fill <= fill + 4'h1;
        end
    end
    assign fifo_full_o = (fill == 4'h8);
    // CPU side counts every break pulse it takes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brk_count_o <= 8'h0;
        end else if (brk_req_i) begin
            brk_count_o <= brk_count_o + 8'h1;
        end
    end
endmodule // dtc_far_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic clk, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat;
    logic secure = 1'h0, bus_read = 1'h0, hit_a = 1'h0, hit_b = 1'h0;
    logic begin_trace = 1'h0, trig_sel = 1'h0, run_done = 1'h0;
    logic clear = 1'h0, ack, ma, mb, capture, mod_en, armed, brk;
    logic tag_o, irq, full;
    logic [7:0] brk_count, cnt;
    int errors = 0;
    int total_checks = 0;
    int n, lat;
    dtc_debug_trigger_control dtc_debug_trigger_control_i (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .secure_i(secure),
        .bus_read_i(bus_read), .cmp_a_hit_i(hit_a), .cmp_b_hit_i(hit_b),
        .begin_trace_i(begin_trace), .trigger_source_select_i(trig_sel),
        .fifo_full_i(full), .run_done_i(run_done), .cmp_a_match_o(ma),
        .cmp_b_match_o(mb), .capture_o(capture), .module_enabled_o(mod_en),
        .armed_o(armed), .brk_req_o(brk), .brk_tag_o(tag_o), .irq_o(irq));
    dtc_far_model dtc_far_model_i (
        .clk_i(clk), .rst_i(rst), .capture_i(capture), .brk_req_i(brk),
        .clear_i(clear), .fifo_full_o(full), .brk_count_o(brk_count));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // Classic single cycle; hold until ack, then release
    task automatic bus(input logic w, input logic [3:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic fire(input logic b);
        @(posedge clk);
        hit_a <= ~b;
        hit_b <= b;
        @(posedge clk);
        hit_a <= 1'h0;
        hit_b <= 1'h0;
    endtask
    task automatic wait_brk();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (brk !== 1'h1 && n < 40);
    endtask
    task automatic fill_run(input logic [7:0] c);
        @(posedge clk);
        clear <= 1'h1;
        @(posedge clk);
        clear <= 1'h0;
        wr(4'h0, {24'h0, c});
        repeat (2) @(posedge clk);
        fire(1'h0);
    endtask
    initial begin
        #100000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        rdc(4'h0, 32'h0);
        chk1(mod_en, 1'h0);
        secure <= 1'h1;
        wr(4'h0, 32'h80);
        rdc(4'h0, 32'h0);
        secure <= 1'h0;
        wr(4'h0, 32'h80);
        rdc(4'h0, 32'h80);
        wr(4'h0, 32'hc0);
        @(negedge clk);
        chk1(armed, 1'h1);
        rdc(4'h4, 32'h3);
        wr(4'h0, 32'h80);
        @(negedge clk);
        chk1(armed, 1'h0);
        for (int i = 0; i < 64; i++) begin
            wr(4'h0, {24'h0, 1'h1, i[5], 2'h0, i[3:0]});
            @(posedge clk);
            bus_read <= i[4];
            hit_a <= 1'h1;
            hit_b <= 1'h1;
            @(negedge clk);
            chk1(ma, i[5] & (~i[2] | (i[3] == i[4])));
            chk1(mb, i[5] & (~i[0] | (i[1] == i[4])));
            @(posedge clk);
            hit_a <= 1'h0;
            hit_b <= 1'h0;
        end
        // Interrupt: masked, unmasked, cleared by read
        wr(4'hc, 32'h0);
        rdc(4'h8, 32'h3);
        wr(4'h0, 32'hc0);
        @(posedge clk);
        run_done <= 1'h1;
        @(posedge clk);
        run_done <= 1'h0;
        @(negedge clk);
        chk1(irq, 1'h0);
        rdc(4'h0, 32'h80);
        wr(4'hc, 32'h2);
        @(negedge clk);
        chk1(irq, 1'h1);
        rdc(4'h8, 32'h2);
        @(negedge clk);
        chk1(irq, 1'h0);
        wr(4'h3, 32'hff);
        rdc(4'h3, 32'h0);
        rdc(4'h0, 32'h80);
        sel <= 4'he;
        wr(4'h0, 32'h0);
        sel <= 4'hf;
        rdc(4'h0, 32'h80);
        for (int i = 0; i < 4; i++) begin
            trig_sel <= i[1];
            wr(4'h0, {24'h0, 2'h3, i[0], 5'h10});
            repeat (2) @(posedge clk);
            fire(i[1]);
            wait_brk();
            chk1(brk, 1'h1);
            chk1(tag_o, i[0]);
            if (i == 0) lat = n;
            chk(n, lat);
            rdc(4'h0, {24'h0, 2'h2, i[0], 5'h10});
        end
        trig_sel <= 1'h0;
        begin_trace <= 1'h1;
        fill_run(8'hd0);
        wait_brk();
        chk1(brk, 1'h1);
        chk1(full, 1'h1);
        @(negedge clk);
        cnt = brk_count;
        fill_run(8'he0);
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk1(full, 1'h1);
        chk({24'h0, brk_count}, {24'h0, cnt});
        complete_run();
    end
endmodule // testbench
